// File: rtl/sag_store_unit.sv
// Purpose: store execution path: address forming, alignment, lane select, pointer update
// Assumes: one request per cycle, the register files live here and are loaded via writes
// Notes: the pointer update happens on the accept edge; the memory write is registered there and lands in memory one edge later
//
// Overview of operation
// RQ1: word post-increment/decrement writes current address, then steps pointer by four.
// RQ2: word short form adds unsigned six-bit multiple-of-four offset.
// RQ3: word long form adds or subtracts signed eighteen-bit word offset.
// RQ4: frame-relative word store subtracts seven-bit multiple-of-four offset.
// RQ5: any pointer, frame and stack pointer included, serves as base.
// RQ6: index-increment mode stores, then adds the increment register to pointer.
// RQ7: software must name distinct pointers for address and increment.
// RQ8: short-encoded stores may share a parallel issue group.
// RQ9: long-encoded stores issued in a parallel group are refused.
// RQ10: high half store writes data bits 31 to 16.
// RQ11: low half store writes data bits 15 to 0.
// RQ12: half stores take base from index or pointer register.
// RQ13: odd half-word address raises misaligned exception.
// RQ14: high half post-step exists only on index registers, by two.
// RQ15: low half post-increment/decrement steps pointer by two.
// RQ16: low half short form adds even offset from zero to thirty.
// RQ17: low half long form adds or subtracts signed seventeen-bit even offset.
// RQ18: index updates wrap circularly when length nonzero.
// RQ19: index, length and base registers are not reset.
// RQ20: word store writes all thirty-two bits of data or pointer.
// RQ21: word address not a multiple of four raises misaligned exception.
// RQ22: misaligned store neither writes memory nor updates its pointer.
// RQ23: stores leave status flags untouched, in any privilege mode.
`timescale 1ns/1ns
module sag_store_unit (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // store request
    input wire logic reqValid,
    input wire sag_pkg::sag_req_t req,
    output logic reqReady,
    // register file loads
    input wire logic dataWe,
    input wire logic [2:0] dataSel,
    input wire logic [31:0] dataVal,
    input wire logic ptrWe,
    input wire logic [2:0] ptrSel,
    input wire logic [31:0] ptrVal,
    input wire logic dagWe,
    input wire logic [1:0] dagFile,
    input wire logic [1:0] dagSel,
    input wire logic [31:0] dagVal,
    // data memory port
    output logic memWrite,
    output sag_pkg::sag_mem_t mem,
    // exceptions
    output logic misaligned,
    output logic illegalIssue,
    // status flags pass through untouched
    input wire logic [31:0] flagsIn,
    output logic [31:0] flagsOut
);
    // ------------------------------------------------------------
    // reset synchroniser
    // ------------------------------------------------------------
    logic rstMeta;
    logic rstSync;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // ------------------------------------------------------------
    // register files
    // ------------------------------------------------------------
    logic [31:0] dataReg [8];
    logic [31:0] ptrReg [8];
    logic [31:0] indexReg [4];
    logic [31:0] modReg [4];
    logic [31:0] lenReg [4];
    logic [31:0] baseReg [4];

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] zext(input logic [17:0] v, input int w);
        logic [31:0] r;
        r = 32'h0000_0000;
        for (int i = 0; i < 18; i++) begin
            if (i < w) begin
                r[i] = v[i];
            end
        end
        return r;
    endfunction : zext

    function automatic logic [31:0] sext(input logic [17:0] v, input int w);
        logic [31:0] r;
        r = zext(v, w);
        for (int i = 0; i < 32; i++) begin
            if (i >= w) begin
                r[i] = v[w-1];
            end
        end
        return r;
    endfunction : sext

    // ------------------------------------------------------------
    // address forming
    // ------------------------------------------------------------
    logic [31:0] baseVal;
    logic [31:0] ofs;
    logic [31:0] effAddr;
    logic [31:0] step;
    logic updPtr;
    logic updIdx;
    logic aligned;
    logic refused;
    logic go;
    logic [31:0] wrapped;

    always_comb begin
        baseVal = req.useIndex ? indexReg[req.idx] : ptrReg[req.basePtr]; // see RQ5, RQ12
        if (req.mode == sag_pkg::SAG_FRAME_REL) begin
            baseVal = ptrReg[sag_pkg::FRAME_POINTER_IDX];
        end
        ofs = 32'h0000_0000;
        unique case (req.mode)
            sag_pkg::SAG_SHORT_OFS: begin
                if (req.kind == sag_pkg::SAG_WORD) begin
                    ofs = zext(req.imm, sag_pkg::SHORT_WORD_OFS_W); // see RQ2
                end else begin
                    ofs = zext(req.imm, sag_pkg::SHORT_HALF_OFS_W); // see RQ16
                end
            end
            sag_pkg::SAG_LONG_OFS: begin
                if (req.kind == sag_pkg::SAG_WORD) begin
                    ofs = sext(req.imm, sag_pkg::LONG_WORD_OFS_W); // see RQ3
                end else begin
                    ofs = sext(req.imm, sag_pkg::LONG_HALF_OFS_W); // see RQ17
                end
                if (req.subtract) begin
                    ofs = 32'h0000_0000 - ofs;
                end
            end
            sag_pkg::SAG_FRAME_REL: begin
                ofs = 32'h0000_0000 - zext(req.imm, sag_pkg::FRAME_WORD_OFS_W); // see RQ4
            end
            sag_pkg::SAG_INDIRECT, sag_pkg::SAG_POST_INC, sag_pkg::SAG_POST_DEC,
            sag_pkg::SAG_INDEX_INC: begin
                ofs = 32'h0000_0000;
            end
            default: begin
                ofs = 32'h0000_0000;
            end
        endcase
        effAddr = baseVal + ofs; // post-modify forms use the current pointer, see RQ1
    end

    always_comb begin
        if (req.kind == sag_pkg::SAG_WORD) begin
            aligned = (effAddr[1:0] == 2'b00); // see RQ21
        end else begin
            aligned = (effAddr[0] == 1'b0); // see RQ13
        end
        // long encodings may not sit in a parallel group; short ones may
        refused = req.wide && req.parallel; // see RQ9, RQ8
    end

    always_comb begin
        step = 32'h0000_0000;
        updPtr = 1'b0;
        updIdx = 1'b0;
        unique case (req.mode)
            sag_pkg::SAG_POST_INC, sag_pkg::SAG_POST_DEC: begin
                step = (req.kind == sag_pkg::SAG_WORD) ? sag_pkg::WORD_STEP
                                                       : sag_pkg::HALF_STEP; // see RQ1, RQ15
                if (req.mode == sag_pkg::SAG_POST_DEC) begin
                    step = 32'h0000_0000 - step;
                end
                // high half post-step is index-only, see RQ14
                updIdx = req.useIndex;
                updPtr = !req.useIndex && (req.kind != sag_pkg::SAG_HALF_HI);
            end
            sag_pkg::SAG_INDEX_INC: begin
                step = req.useIndex ? modReg[req.modIdx] : ptrReg[req.incPtr]; // see RQ6
                updIdx = req.useIndex;
                updPtr = !req.useIndex;
            end
            sag_pkg::SAG_INDIRECT, sag_pkg::SAG_SHORT_OFS, sag_pkg::SAG_LONG_OFS,
            sag_pkg::SAG_FRAME_REL: begin
                step = 32'h0000_0000;
            end
            default: begin
                step = 32'h0000_0000;
            end
        endcase
    end

    sag_circ_wrap u_wrap (
        .index(indexReg[req.idx]),
        .base(baseReg[req.idx]),
        .length(lenReg[req.idx]),
        .step(step),
        .nextIndex(wrapped)
    );

    assign reqReady = rstSync;
    assign go = reqValid && reqReady && aligned && !refused; // see RQ22

    // ------------------------------------------------------------
    // register file updates (no reset on dag registers)
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (dataWe) begin
            dataReg[dataSel] <= dataVal;
        end
    end

    always_ff @(posedge clk) begin
        if (ptrWe) begin
            ptrReg[ptrSel] <= ptrVal;
        end
        if (go && updPtr) begin
            ptrReg[req.basePtr] <= ptrReg[req.basePtr] + step; // see RQ1, RQ6, RQ15
        end
    end

    // index, length and base are left uninitialised by reset, see RQ19
    always_ff @(posedge clk) begin
        if (dagWe && dagFile == 2'h0) begin
            indexReg[dagSel] <= dagVal;
        end
        if (go && updIdx) begin
            indexReg[req.idx] <= wrapped; // see RQ18
        end
        if (dagWe && dagFile == 2'h1) begin
            modReg[dagSel] <= dagVal;
        end
        if (dagWe && dagFile == 2'h2) begin
            lenReg[dagSel] <= dagVal;
        end
        if (dagWe && dagFile == 2'h3) begin
            baseReg[dagSel] <= dagVal;
        end
    end

    // ------------------------------------------------------------
    // memory port and exceptions
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            memWrite <= 1'b0;
            mem <= '0;
            misaligned <= 1'b0;
            illegalIssue <= 1'b0;
        end else begin
            memWrite <= go;
            misaligned <= reqValid && reqReady && !refused && !aligned;
            illegalIssue <= reqValid && reqReady && refused;
            if (go) begin
                mem.addr <= effAddr;
                unique case (req.kind)
                    sag_pkg::SAG_WORD: begin
                        mem.wdata <= req.srcIsPointer ? ptrReg[req.srcReg]
                                                      : dataReg[req.srcReg]; // see RQ20
                        mem.lanes <= sag_pkg::LANE_WORD;
                    end
                    sag_pkg::SAG_HALF_HI: begin
                        mem.wdata <= {dataReg[req.srcReg][31:16],
                                      dataReg[req.srcReg][31:16]}; // see RQ10
                        mem.lanes <= effAddr[1] ? sag_pkg::LANE_HALF_HI
                                                : sag_pkg::LANE_HALF_LO;
                    end
                    sag_pkg::SAG_HALF_LO: begin
                        mem.wdata <= {dataReg[req.srcReg][15:0],
                                      dataReg[req.srcReg][15:0]}; // see RQ11
                        mem.lanes <= effAddr[1] ? sag_pkg::LANE_HALF_HI
                                                : sag_pkg::LANE_HALF_LO;
                    end
                    default: begin
                        mem.lanes <= 4'h0;
                    end
                endcase
            end
        end
    end

    // stores never touch arithmetic flags, see RQ23
    assign flagsOut = flagsIn;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_word_align;
        @(posedge clk) disable iff (!rstSync)
        memWrite && mem.lanes == sag_pkg::LANE_WORD |-> mem.addr[1:0] == 2'b00;
    endproperty
    a_word_align: assert property (p_word_align) else $error("word write unaligned"); // see RQ21

    property p_half_align;
        @(posedge clk) disable iff (!rstSync)
        memWrite && mem.lanes != sag_pkg::LANE_WORD |-> !mem.addr[0];
    endproperty
    a_half_align: assert property (p_half_align) else $error("half write odd"); // see RQ13

    property p_no_write_on_fault;
        @(posedge clk) disable iff (!rstSync)
        reqValid && !aligned && !refused && !ptrWe
        |=> misaligned && !memWrite && ptrReg[$past(req.basePtr)] == $past(ptrReg[req.basePtr]);
    endproperty
    a_no_write_on_fault: assert property (p_no_write_on_fault) else $error("faulted write"); // see RQ22

    property p_wide_refused;
        @(posedge clk) disable iff (!rstSync)
        reqValid && req.wide && req.parallel |=> illegalIssue && !memWrite;
    endproperty
    a_wide_refused: assert property (p_wide_refused) else $error("wide parallel taken"); // see RQ9

    property p_post_inc_word;
        @(posedge clk) disable iff (!rstSync)
        go && req.kind == sag_pkg::SAG_WORD && req.mode == sag_pkg::SAG_POST_INC
            && !req.useIndex && !ptrWe
        |=> ptrReg[$past(req.basePtr)] == $past(effAddr) + sag_pkg::WORD_STEP
            && mem.addr == $past(effAddr);
    endproperty
    a_post_inc_word: assert property (p_post_inc_word) else $error("word post-inc wrong"); // see RQ1

    property p_half_post_dec;
        @(posedge clk) disable iff (!rstSync)
        go && req.kind == sag_pkg::SAG_HALF_LO && req.mode == sag_pkg::SAG_POST_DEC
            && !req.useIndex && !ptrWe
        |=> ptrReg[$past(req.basePtr)] == $past(effAddr) - sag_pkg::HALF_STEP;
    endproperty
    a_half_post_dec: assert property (p_half_post_dec) else $error("half post-dec wrong"); // see RQ15

    property p_hi_lane;
        @(posedge clk) disable iff (!rstSync)
        go && req.kind == sag_pkg::SAG_HALF_HI
        |=> mem.wdata[15:0] == $past(dataReg[req.srcReg][31:16]);
    endproperty
    a_hi_lane: assert property (p_hi_lane) else $error("high half data wrong"); // see RQ10

    property p_frame_rel;
        @(posedge clk) disable iff (!rstSync)
        go && req.mode == sag_pkg::SAG_FRAME_REL
        |=> mem.addr == $past(ptrReg[sag_pkg::FRAME_POINTER_IDX])
            - {25'h0, $past(req.imm[6:0])};
    endproperty
    a_frame_rel: assert property (p_frame_rel) else $error("frame address wrong"); // see RQ4

    property p_linear_idx;
        @(posedge clk) disable iff (!rstSync)
        go && updIdx && lenReg[req.idx] == 32'h0000_0000 && !dagWe
        |=> indexReg[$past(req.idx)] == $past(indexReg[req.idx]) + $past(step);
    endproperty
    a_linear_idx: assert property (p_linear_idx) else $error("linear index wrong"); // see RQ18

    c_word_post: cover property (@(posedge clk) disable iff (!rstSync)
        go && req.mode == sag_pkg::SAG_POST_INC);
    c_misalign: cover property (@(posedge clk) disable iff (!rstSync) misaligned);
    c_wrap: cover property (@(posedge clk) disable iff (!rstSync)
        go && updIdx && wrapped != indexReg[req.idx] + step);
    c_index_inc: cover property (@(posedge clk) disable iff (!rstSync)
        go && req.mode == sag_pkg::SAG_INDEX_INC);

endmodule : sag_store_unit

// File: rtl/sag_pkg.sv
// Purpose: shared types and constants for the store address generation block
// Assumes: 32-bit byte addresses, 8 data, 8 pointer and 4 index/modify/length/base registers
// Notes: no registers are reachable by software; the core drives the request port
package sag_pkg;

    // ------------------------------------------------------------
    // store kinds and addressing modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SAG_WORD,
        SAG_HALF_HI,
        SAG_HALF_LO
    } sag_kind_t;

    typedef enum logic [2:0] {
        SAG_INDIRECT,
        SAG_POST_INC,
        SAG_POST_DEC,
        SAG_SHORT_OFS,
        SAG_LONG_OFS,
        SAG_FRAME_REL,
        SAG_INDEX_INC
    } sag_mode_t;

    // ------------------------------------------------------------
    // register indices and widths
    // ------------------------------------------------------------
    localparam logic [2:0] STACK_POINTER_IDX = 3'h6;
    localparam logic [2:0] FRAME_POINTER_IDX = 3'h7;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;
    localparam logic [31:0] HALF_STEP = 32'h0000_0002;
    localparam int SHORT_WORD_OFS_W = 6;
    localparam int FRAME_WORD_OFS_W = 7;
    localparam int LONG_WORD_OFS_W = 18;
    localparam int SHORT_HALF_OFS_W = 5;
    localparam int LONG_HALF_OFS_W = 17;
    localparam logic [3:0] LANE_WORD = 4'hF;
    localparam logic [3:0] LANE_HALF_LO = 4'h3;
    localparam logic [3:0] LANE_HALF_HI = 4'hC;

    // ------------------------------------------------------------
    // request and memory carriers
    // ------------------------------------------------------------
    typedef struct packed {
        sag_kind_t kind;
        sag_mode_t mode;
        logic useIndex;      // base is an index register, not a pointer
        logic srcIsPointer;  // word store of a pointer register
        logic wide;          // 32-bit encoding
        logic parallel;      // issued within a parallel group
        logic [2:0] basePtr;
        logic [2:0] incPtr;
        logic [1:0] idx;
        logic [1:0] modIdx;
        logic [2:0] srcReg;
        logic [17:0] imm;    // byte offset, signed for long forms
        logic subtract;      // long form subtracts its offset
    } sag_req_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0] lanes;
    } sag_mem_t;

endpackage : sag_pkg

// File: rtl/sag_circ_wrap.sv
// Purpose: circular-buffer wrap of an updated index register
// Assumes: length of zero means plain linear update
// Notes: handles one wrap per update, steps larger than the length are not folded
`timescale 1ns/1ns
module sag_circ_wrap (
    // current state of the buffer
    input wire logic [31:0] index,
    input wire logic [31:0] base,
    input wire logic [31:0] length,
    // signed step to apply
    input wire logic [31:0] step,
    // wrapped result
    output logic [31:0] nextIndex
);
    logic [31:0] linear;
    logic [31:0] top;
    always_comb begin
        linear = index + step;
        top = base + length;
        nextIndex = linear;
        if (length != 32'h0000_0000) begin
            if (step[31] && (linear < base || linear > index)) begin
                nextIndex = linear + length;
            end else if (!step[31] && linear >= top) begin
                nextIndex = linear - length;
            end
        end
    end
endmodule : sag_circ_wrap

// File: dv/sag_mem_model.sv
// Purpose: behavioural model of the core data memory port behind the store unit
// Assumes: byte lanes select which bytes of the addressed word are written
// Notes: unwritten words read back as zero; the bench reads words through rd()
`timescale 1ns/1ns
module sag_mem_model (
    // clock
    input wire logic clk,
    // data memory port
    input wire logic memWrite,
    input wire sag_pkg::sag_mem_t mem,
    // activity
    output int wrCount
);
    logic [31:0] store [logic [31:0]];

    function automatic logic [31:0] rd(input logic [31:0] a);
        return store.exists(a) ? store[a] : 32'h0000_0000;
    endfunction : rd

    // ------------------------------------------------------------
    // lane merge
    // ------------------------------------------------------------
    // the word is addressed by its aligned base, only enabled bytes change
    always @(posedge clk) begin
        logic [31:0] wa;
        logic [31:0] w;
        if (memWrite) begin
            wa = mem.addr & ~32'h0000_0003;
            w = rd(wa);
            for (int i = 0; i < 4; i++) begin
                if (mem.lanes[i]) begin
                    w[8*i +: 8] = mem.wdata[8*i +: 8];
                end
            end
            store[wa] = w;
            wrCount++;
        end
    end
endmodule : sag_mem_model

// File: dv/tb.sv
// Purpose: self-checking bench of the store unit against a memory model
// Assumes: inputs change on the falling edge, answers settle one edge after taking
// Notes: register files are loaded after reset since they keep no reset value
`timescale 1ns/1ns
module tb;
    localparam sag_pkg::sag_kind_t KW = sag_pkg::SAG_WORD;
    localparam sag_pkg::sag_kind_t KH = sag_pkg::SAG_HALF_HI;
    localparam sag_pkg::sag_kind_t KL = sag_pkg::SAG_HALF_LO;
    localparam sag_pkg::sag_mode_t MI = sag_pkg::SAG_INDIRECT;
    localparam sag_pkg::sag_mode_t MPI = sag_pkg::SAG_POST_INC;
    localparam sag_pkg::sag_mode_t MPD = sag_pkg::SAG_POST_DEC;
    localparam sag_pkg::sag_mode_t MS = sag_pkg::SAG_SHORT_OFS;
    localparam sag_pkg::sag_mode_t ML = sag_pkg::SAG_LONG_OFS;
    localparam sag_pkg::sag_mode_t MF = sag_pkg::SAG_FRAME_REL;
    localparam sag_pkg::sag_mode_t MX = sag_pkg::SAG_INDEX_INC;

    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic reqValid = 1'b0;
    sag_pkg::sag_req_t req = '0;
    logic reqReady;
    logic dataWe = 1'b0;
    logic [2:0] dataSel = 3'h0;
    logic ptrWe = 1'b0;
    logic dagWe = 1'b0;
    logic [1:0] dagFile = 2'h0;
    logic [31:0] regVal = 32'h0000_0000;
    logic memWrite;
    sag_pkg::sag_mem_t mem;
    logic misaligned;
    logic illegalIssue;
    logic [31:0] flagsIn = 32'h5A5A_F00F;
    logic [31:0] flagsOut;
    int numErrors = 0;
    int cmpCount = 0;
    sag_pkg::sag_req_t r;

    sag_store_unit uut (.clk(clk), .rst_b(rst_b), .reqValid(reqValid), .req(req),
        .reqReady(reqReady), .dataWe(dataWe), .dataSel(dataSel), .dataVal(regVal),
        .ptrWe(ptrWe), .ptrSel(dataSel), .ptrVal(regVal), .dagWe(dagWe),
        .dagFile(dagFile), .dagSel(dataSel[1:0]), .dagVal(regVal),
        .memWrite(memWrite), .mem(mem), .misaligned(misaligned),
        .illegalIssue(illegalIssue), .flagsIn(flagsIn), .flagsOut(flagsOut));

    sag_mem_model mdl (.clk(clk), .memWrite(memWrite), .mem(mem), .wrCount());

    initial begin
        forever #20 clk = ~clk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic finishTest;
        $display("errors %0d, comparisons %0d", numErrors, cmpCount);
        if (numErrors == 0 && cmpCount > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finishTest

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        cmpCount++;
        if (seen !== exp) begin
            numErrors++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    function automatic logic [31:0] msk(input logic [3:0] l);
        return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
    endfunction : msk

    function automatic sag_pkg::sag_req_t mk(input sag_pkg::sag_kind_t k,
        input sag_pkg::sag_mode_t m, input int ui, input int b, input int inc,
        input int s, input int imm, input int sub, input int w);
        return '{kind: k, mode: m, useIndex: 1'(ui), srcIsPointer: 1'b0, wide: 1'(w),
            parallel: 1'b0, basePtr: 3'(b), incPtr: 3'(inc), idx: 2'(b),
            modIdx: 2'(inc), srcReg: 3'(s), imm: 18'(imm), subtract: 1'(sub)};
    endfunction : mk

    // k: 0 data, 1 pointer, 2 address-generator file f
    task automatic wr(input int k, input int f, input int s, input logic [31:0] v);
        @(negedge clk);
        dataWe = (k == 0);
        ptrWe = (k == 1);
        dagWe = (k == 2);
        dagFile = 2'(f);
        dataSel = 3'(s);
        regVal = v;
        @(negedge clk);
        dataWe = 1'b0;
        ptrWe = 1'b0;
        dagWe = 1'b0;
    endtask : wr

    task automatic st(input sag_pkg::sag_req_t q, input logic [31:0] eAddr,
        input logic [3:0] eLanes, input logic [31:0] eData);
        @(negedge clk);
        reqValid = 1'b1;
        req = q;
        @(negedge clk);
        reqValid = 1'b0;
        chk(32'(memWrite), 32'h1, "write pulse");
        chk(32'(misaligned), 32'h0, "misaligned flag");
        chk(mem.addr, eAddr, "address");
        chk(32'(mem.lanes), 32'(eLanes), "lanes");
        chk(flagsOut, flagsIn, "flags");
        @(negedge clk);
        chk(mdl.rd(eAddr & ~32'h0000_0003) & msk(eLanes), eData & msk(eLanes), "stored");
    endtask : st

    task automatic bad(input sag_pkg::sag_req_t q, input logic eMis, input logic eIll);
        int n;
        n = mdl.wrCount;
        @(negedge clk);
        reqValid = 1'b1;
        req = q;
        @(negedge clk);
        reqValid = 1'b0;
        chk(32'(memWrite), 32'h0, "refused write");
        chk(32'(misaligned), 32'(eMis), "misaligned flag");
        chk(32'(illegalIssue), 32'(eIll), "illegal issue flag");
        @(negedge clk);
        chk(32'(mdl.wrCount), 32'(n), "write count");
    endtask : bad

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic tWord;
        st(mk(KW, MPI, 0, 2, 0, 3, 0, 0, 0), 32'h2000, 4'hF, 32'hA1B2C3D4);
        st(mk(KW, MI, 0, 2, 0, 3, 0, 0, 0), 32'h2004, 4'hF, 32'hA1B2C3D4);
        st(mk(KW, MPD, 0, 2, 0, 5, 0, 0, 0), 32'h2004, 4'hF, 32'h12345678);
        st(mk(KW, MI, 0, 2, 0, 5, 0, 0, 0), 32'h2000, 4'hF, 32'h12345678);
        st(mk(KW, MS, 0, 0, 0, 3, 60, 0, 0), 32'h103C, 4'hF, 32'hA1B2C3D4);
        st(mk(KW, ML, 0, 2, 0, 5, 'h1004, 1, 1), 32'h0FFC, 4'hF, 32'h12345678);
        st(mk(KW, ML, 0, 2, 0, 3, -4, 0, 1), 32'h1FFC, 4'hF, 32'hA1B2C3D4);
        st(mk(KW, MF, 0, 7, 0, 5, 28, 0, 0), 32'h3FE4, 4'hF, 32'h12345678);
        r = mk(KW, MI, 0, 6, 0, 1, 0, 0, 0);
        r.srcIsPointer = 1'b1;
        st(r, 32'h3000, 4'hF, 32'h0000_0010);
    endtask : tWord

    // address and increment are always distinct registers here
    task automatic tIndexInc;
        st(mk(KW, MX, 0, 0, 1, 3, 0, 0, 0), 32'h1000, 4'hF, 32'hA1B2C3D4);
        st(mk(KW, MI, 0, 0, 0, 3, 0, 0, 0), 32'h1010, 4'hF, 32'hA1B2C3D4);
        st(mk(KW, MX, 1, 0, 0, 5, 0, 0, 0), 32'h0200, 4'hF, 32'h12345678);
        st(mk(KW, MI, 1, 0, 0, 5, 0, 0, 0), 32'h0204, 4'hF, 32'h12345678);
    endtask : tIndexInc

    task automatic tHalf;
        st(mk(KH, MPI, 1, 0, 0, 3, 0, 0, 0), 32'h0204, 4'h3, 32'hA1B2A1B2);
        st(mk(KH, MI, 1, 0, 0, 3, 0, 0, 0), 32'h0206, 4'hC, 32'hA1B2A1B2);
        st(mk(KH, MPD, 1, 0, 0, 3, 0, 0, 0), 32'h0206, 4'hC, 32'hA1B2A1B2);
        st(mk(KH, MI, 0, 0, 0, 3, 0, 0, 0), 32'h1010, 4'h3, 32'hA1B2A1B2);
        st(mk(KL, MS, 0, 0, 0, 5, 30, 0, 0), 32'h102E, 4'hC, 32'h56785678);
        st(mk(KL, ML, 0, 2, 0, 5, 'h102, 1, 1), 32'h1EFE, 4'hC, 32'h56785678);
        st(mk(KL, ML, 0, 2, 0, 5, -2, 0, 1), 32'h1FFE, 4'hC, 32'h56785678);
        st(mk(KL, MPI, 0, 2, 0, 5, 0, 0, 0), 32'h2000, 4'h3, 32'h56785678);
        st(mk(KL, MPD, 0, 2, 0, 5, 0, 0, 0), 32'h2002, 4'hC, 32'h56785678);
        st(mk(KL, MI, 0, 2, 0, 5, 0, 0, 0), 32'h2000, 4'h3, 32'h56785678);
    endtask : tHalf

    // index 1 spans 0x100..0x107, so steps from either end must fold back
    task automatic tCirc;
        st(mk(KL, MPI, 1, 1, 0, 5, 0, 0, 0), 32'h0106, 4'hC, 32'h56785678);
        st(mk(KL, MI, 1, 1, 0, 5, 0, 0, 0), 32'h0100, 4'h3, 32'h56785678);
        st(mk(KL, MPD, 1, 1, 0, 5, 0, 0, 0), 32'h0100, 4'h3, 32'h56785678);
        st(mk(KL, MI, 1, 1, 0, 5, 0, 0, 0), 32'h0106, 4'hC, 32'h56785678);
    endtask : tCirc

    task automatic tRefuse;
        bad(mk(KL, MI, 0, 3, 0, 5, 0, 0, 0), 1'b1, 1'b0);
        bad(mk(KW, MPI, 0, 4, 0, 3, 0, 0, 0), 1'b1, 1'b0);
        st(mk(KL, MI, 0, 4, 0, 5, 0, 0, 0), 32'h1002, 4'hC, 32'h56785678);
        r = mk(KW, ML, 0, 2, 0, 3, 4, 0, 1);
        r.parallel = 1'b1;
        bad(r, 1'b0, 1'b1);
        r = mk(KW, MS, 0, 2, 0, 3, 8, 0, 0);
        r.parallel = 1'b1;
        st(r, 32'h2008, 4'hF, 32'hA1B2C3D4);
    endtask : tRefuse

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(negedge clk);
        chk(32'(memWrite), 32'h0, "write in reset");
        chk(32'(misaligned), 32'h0, "misaligned in reset");
        rst_b = 1'b1;
        for (int i = 0; i < 10 && reqReady !== 1'b1; i++) begin
            @(negedge clk);
        end
        chk(32'(reqReady), 32'h1, "ready after reset");
        // register files hold no reset value, so every used one is loaded
        wr(0, 0, 3, 32'hA1B2C3D4);
        wr(0, 0, 5, 32'h12345678);
        wr(1, 0, 0, 32'h1000);
        wr(1, 0, 1, 32'h0010);
        wr(1, 0, 2, 32'h2000);
        wr(1, 0, 3, 32'h1001);
        wr(1, 0, 4, 32'h1002);
        wr(1, 0, 6, 32'h3000);
        wr(1, 0, 7, 32'h4000);
        wr(2, 0, 0, 32'h0200);
        wr(2, 1, 0, 32'h0004);
        wr(2, 2, 0, 32'h0000);
        wr(2, 0, 1, 32'h0106);
        wr(2, 2, 1, 32'h0008);
        wr(2, 3, 1, 32'h0100);
        tWord();
        tIndexInc();
        tHalf();
        tCirc();
        tRefuse();
        finishTest();
    end

    initial begin
        repeat (3000) @(posedge clk);
        numErrors++;
        finishTest();
    end
endmodule : tb
